// [int_multiply_divide_unit.sv]
// Integer multiply step, full multiply and divide unit with an APB port.
// Notes on behaviour
// - Extension code 100100 is multiply step; it always updates the flags.
// - Multiply step shifts source A and extension word as one 64-bit pair.
// - Step addend is source B, or signed immediate when select is one.
// - Shifted value is source A right one, top bit below_zero xor excess.
// - Addend is added when extension bit zero is one, else zero is added.
// - Sum goes to destination; flags are set as for a flag-setting add.
// - Extension word shifts right, its top bit from source A bit zero.
// - Codes 001010 and 011010 are unsigned multiply, without and with flags.
// - Codes 001011 and 011011 are signed multiply, without and with flags.
// - Product high word goes to extension register, low word to destination.
// - Multiply second operand is source B or signed immediate by select.
// - Unsigned multiply is unsigned; signed multiply is two's complement.
// - Non-flag multiplies leave all condition flags unchanged.
// - Flag multiplies set below_zero from bit 31, all_clear from low word.
// - Flag multiplies clear excess and borrow; software must not test them.
// - Codes 001110 and 011110 are unsigned divide, without and with flags.
// - Codes 001111 and 011111 are signed divide, without and with flags.
// - Divide extension word over source A by a 32-bit divisor.
// - Overflowing quotients saturate to the largest value of the right sign.
// - Signed division truncates toward zero.
// - Flag divides set sign and zero from quotient, excess on overflow.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`include "mdu_map.svh"
module int_multiply_divide_unit (
   // Clock and reset.
   input  wire logic              i_sys_clk,
   input  wire logic              i_rstn,
   // APB request.
   input  wire mdu_pkg::apb_req_t i_apb,
   // APB answer.
   output logic [31:0]            o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr
);
   import mdu_pkg::*;

   instr_t           instr_q;
   proc_state_word_t icc_q;
   unit_state_t      state_q;
   logic [31:0]      opa_q;
   logic [31:0]      opb_q;
   logic [31:0]      y_q;
   logic [31:0]      res_q;
   logic [31:0]      prdata_q;
   logic             divzero_q;
   logic             illegal_q;
   logic             stall_q;
   logic             dsig_q;
   logic             dcc_q;
   logic             qneg_q;
   logic             div_done;
   logic [63:0]      qmag;

   wire busy = state_q == ST_DIVIDE;

   // Address decode of the register window.
   wire [7:0] addr      = i_apb.paddr;
   wire       sel_instr = addr == `MDU_INSTR_OFS;
   wire       sel_opa   = addr == `MDU_OPA_OFS;
   wire       sel_opb   = addr == `MDU_OPB_OFS;
   wire       sel_y     = addr == `MDU_YEXT_OFS;
   wire       sel_flags = addr == `MDU_FLAGS_OFS;
   wire       sel_res   = addr == `MDU_RESULT_OFS;
   wire       sel_stat  = addr == `MDU_STATUS_OFS;
   wire       mapped    = sel_instr | sel_opa | sel_opb | sel_y | sel_flags
                          | sel_res | sel_stat;

   // dependent access stall.
   // Every mapped register but status depends on the running divide, so it waits.
   // The extra stall_q cycle lets the read register pick up final values.
   wire stall = busy & i_apb.psel & mapped & ~sel_stat;
   assign o_pready  = ~(stall | stall_q);
   wire   acc       = i_apb.psel & i_apb.penable & o_pready;
   wire   wr        = acc & i_apb.pwrite & mapped;
   wire   go        = wr & sel_instr;
   assign o_pslverr = acc & ~mapped;

   // Read selection; the answer is registered on every cycle with psel high.
   wire [31:0] status = {19'h0, instr_q.dest_field, 5'h0,
                         illegal_q, divzero_q, busy};
   wire [31:0] rmux = sel_instr ? 32'(instr_q) :
                      sel_opa   ? opa_q :
                      sel_opb   ? opb_q :
                      sel_y     ? y_q :
                      sel_flags ? {28'h0, icc_q} :
                      sel_res   ? res_q :
                      sel_stat  ? status : 32'h0;
   assign o_prdata = prdata_q;

   instr_t wd;
   assign wd = instr_t'(i_apb.pwdata);
   wire       fmt_ok = wd.major == `MDU_MAJOR;
   wire [5:0] ext    = wd.opcode_ext_field;

   wire is_mulscc = fmt_ok & (ext == `MDU_EXT_MULSCC);
   wire umul_n    = fmt_ok & (ext == `MDU_EXT_UMUL);
   wire umul_c    = fmt_ok & (ext == `MDU_EXT_UMULCC);
   wire smul_n    = fmt_ok & (ext == `MDU_EXT_SMUL);
   wire smul_c    = fmt_ok & (ext == `MDU_EXT_SMULCC);
   wire udiv_n    = fmt_ok & (ext == `MDU_EXT_UDIV);
   wire udiv_c    = fmt_ok & (ext == `MDU_EXT_UDIVCC);
   wire sdiv_n    = fmt_ok & (ext == `MDU_EXT_SDIV);
   wire sdiv_c    = fmt_ok & (ext == `MDU_EXT_SDIVCC);
   wire is_umul   = umul_n | umul_c;
   wire is_smul   = smul_n | smul_c;
   wire is_mul    = is_umul | is_smul;
   wire mul_cc    = umul_c | smul_c;
   wire is_sdiv   = sdiv_n | sdiv_c;
   wire is_div    = udiv_n | udiv_c | is_sdiv;
   wire div_cc    = udiv_c | sdiv_c;
   wire known     = is_mulscc | is_mul | is_div;

   wire [31:0] imm_ext = {{19{wd.signed_imm_field[12]}}, wd.signed_imm_field};
   wire [31:0] op2     = wd.sel_imm ? imm_ext : opb_q;

   // operand signedness.
   // A single cycle product; timing at full clock rate is the price paid.
   wire        [63:0] uprod = {32'h0, opa_q} * {32'h0, op2};
   wire signed [63:0] sprod = $signed({{32{opa_q[31]}}, opa_q})
                              * $signed({{32{op2[31]}}, op2});
   wire        [63:0] prod  = is_smul ? sprod : uprod;

   wire [31:0] shifted = {icc_q.below_zero ^ icc_q.arith_excess_flag,
                          opa_q[31:1]};
   wire [31:0] addend  = y_q[0] ? op2 : 32'h0;
   wire [32:0] msum    = {1'b0, shifted} + {1'b0, addend};
   wire        mv      = (shifted[31] == addend[31])
                         & (msum[31] != shifted[31]);

   // magnitudes give truncation toward zero.
   // Signed operands divide as magnitudes and the sign is put back after.
   wire [63:0] dvd    = {y_q, opa_q};
   wire        dneg   = is_sdiv & y_q[31];
   wire        vneg   = is_sdiv & op2[31];
   wire [63:0] dmag   = dneg ? 64'h0 - dvd : dvd;
   wire [31:0] vmag   = vneg ? 32'h0 - op2 : op2;
   wire        div_go = go & is_div & (op2 != 32'h0);

   // long division of the extension word above source A.
   mdu_divider u_div (
      .i_sys_clk  (i_sys_clk),
      .i_rstn     (i_rstn),
      .i_start    (div_go),
      .i_dividend (dmag),
      .i_divisor  (vmag),
      .o_done     (div_done),
      .o_quot     (qmag)
   );

   // quotient saturation.
   // Negative overflow uses strict truncation: anything past the limit.
   wire        ovf  = dsig_q ? (qneg_q ? qmag > `MDU_NEG_LIM
                                       : qmag > `MDU_POS_LIM)
                             : qmag[63:32] != 32'h0;
   wire [31:0] qsat = ~dsig_q ? `MDU_SAT_U :
                      qneg_q  ? `MDU_SAT_N : `MDU_SAT_P;
   wire [31:0] qval = ovf ? qsat :
                      qneg_q ? 32'h0 - qmag[31:0] : qmag[31:0];
   wire        fin  = busy & div_done;

   wire        res_we = (go & (is_mulscc | is_mul)) | fin;
   wire [31:0] res_d  = fin ? qval : is_mulscc ? msum[31:0] : prod[31:0];
   wire [31:0] res_n  = res_we ? res_d : res_q;

   // in-place accumulation.
   // Source A is the register file copy; a matching destination updates it.
   wire in_place = fin ? instr_q.dest_field == instr_q.src_a_field
                       : wd.dest_field == wd.src_a_field;
   wire [31:0] opa_d = (res_we & in_place) ? res_d :
                       (wr & sel_opa) ? i_apb.pwdata : opa_q;

   // high product word to extension register.
   wire [31:0] y_d = (go & is_mulscc) ? {opa_q[0], y_q[31:1]} :
                     (go & is_mul)    ? prod[63:32] :
                     (wr & sel_y)     ? i_apb.pwdata : y_q;

   proc_state_word_t icc_step;
   assign icc_step = '{msum[31], msum[31:0] == 32'h0, mv, msum[32]};
   // flags from the low product word.
   proc_state_word_t icc_mul;
   assign icc_mul = '{prod[31], prod[31:0] == 32'h0, 1'b0, 1'b0};
   proc_state_word_t icc_div;
   assign icc_div = '{qval[31], qval == 32'h0, ovf, 1'b0};

   // flags held unless a flag-setting operation completes or the flags register is written.
   proc_state_word_t icc_d;
   assign icc_d = (go & is_mulscc) ? icc_step :
                  (go & mul_cc)    ? icc_mul :
                  (fin & dcc_q)    ? icc_div :
                  (wr & sel_flags) ? proc_state_word_t'(i_apb.pwdata[3:0]) :
                  icc_q;

   wire         op2_zero = op2 == 32'h0;
   unit_state_t state_d;

   // Divide sequencer; a step or multiply never leaves the idle state.
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (div_go) begin
               state_d = ST_DIVIDE;
            end
         end
         ST_DIVIDE: begin
            if (fin) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Operand, result and flag registers.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         opa_q <= `MDU_WORD_RST;
         opb_q <= `MDU_WORD_RST;
         y_q   <= `MDU_WORD_RST;
         res_q <= `MDU_WORD_RST;
         icc_q <= `MDU_FLAGS_RST;
      end else begin
         opa_q <= opa_d;
         opb_q <= (wr & sel_opb) ? i_apb.pwdata : opb_q;
         y_q   <= y_d;
         res_q <= res_n;
         icc_q <= icc_d;
      end
   end

   // Sequencing and bus answer registers.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         instr_q   <= `MDU_WORD_RST;
         state_q   <= ST_IDLE;
         divzero_q <= 1'b0;
         illegal_q <= 1'b0;
         stall_q   <= 1'b0;
         dsig_q    <= 1'b0;
         dcc_q     <= 1'b0;
         qneg_q    <= 1'b0;
         prdata_q  <= `MDU_WORD_RST;
      end else begin
         instr_q   <= go ? wd : instr_q;
         state_q   <= state_d;
         divzero_q <= go ? (is_div & op2_zero) : divzero_q;
         illegal_q <= go ? ~known : illegal_q;
         stall_q   <= stall;
         dsig_q    <= div_go ? is_sdiv : dsig_q;
         dcc_q     <= div_go ? div_cc : dcc_q;
         qneg_q    <= div_go ? (dneg ^ vneg) : qneg_q;
         prdata_q  <= i_apb.psel ? rmux : prdata_q;
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   a_step_noadd: assert property (
      go && is_mulscc && !y_q[0] |=> res_q == {$past(icc_q.below_zero
         ^ icc_q.arith_excess_flag), $past(opa_q[31:1])})
      else $error("Step without add did not keep the shifted value.");
   a_step_shift: assert property (
      go && is_mulscc |=> y_q == {$past(opa_q[0]), $past(y_q[31:1])})
      else $error("Extension word did not shift after a step.");
   a_step_flags: assert property (
      go && is_mulscc |=> icc_q.below_zero == res_q[31]
         && icc_q.all_clear_flag == (res_q == 32'h0))
      else $error("Step flags do not match the step sum.");
   a_mul_split: assert property (
      go && is_umul |=> {y_q, res_q} == $past(uprod))
      else $error("Unsigned product not split over the two words.");
   a_smul_sign: assert property (
      go && is_smul && opa_q == 32'hFFFF_FFFF && op2 == 32'h1
         |=> y_q == 32'hFFFF_FFFF && res_q == 32'hFFFF_FFFF)
      else $error("Signed product of minus one lost its sign.");
   a_mul_keep: assert property (
      go && (umul_n || smul_n) |=> $stable(icc_q))
      else $error("Plain multiply changed the flags.");
   a_mul_nz: assert property (
      go && mul_cc |=> icc_q.below_zero == res_q[31]
         && icc_q.all_clear_flag == (res_q == 32'h0))
      else $error("Multiply sign or zero flag wrong.");
   a_mul_vc: assert property (
      go && mul_cc |=> !icc_q.arith_excess_flag && !icc_q.arith_borrow_out)
      else $error("Multiply left excess or borrow set.");
   a_div_time: assert property (
      $rose(busy) |-> ##[60:70] $fell(busy))
      else $error("Divide did not finish in time.");
   a_div_sat: assert property (
      fin && !dsig_q && qmag[63:32] != 32'h0 |=> res_q == 32'hFFFF_FFFF)
      else $error("Unsigned overflow quotient not saturated.");
   a_div_flags: assert property (
      fin && dcc_q |=> icc_q.all_clear_flag == (res_q == 32'h0)
         && !icc_q.arith_borrow_out)
      else $error("Divide flags wrong.");
   a_dep_stall: assert property (
      busy && i_apb.psel && i_apb.penable && sel_res |-> !o_pready)
      else $error("Result read not stalled during a divide.");

endmodule : int_multiply_divide_unit

// [mdu_map.svh]
// Offsets, opcodes, field positions and limits of the multiply/divide unit.
`ifndef MDU_MAP_SVH
`define MDU_MAP_SVH

// APB byte offsets of the registers.
`define MDU_INSTR_OFS  8'h00
`define MDU_OPA_OFS    8'h04
`define MDU_OPB_OFS    8'h08
`define MDU_YEXT_OFS   8'h0C
`define MDU_FLAGS_OFS  8'h10
`define MDU_RESULT_OFS 8'h14
`define MDU_STATUS_OFS 8'h18

// Reset values.
`define MDU_WORD_RST   32'h0000_0000
`define MDU_FLAGS_RST  4'h0

// Status register field positions.
`define MDU_ST_BUSY    0
`define MDU_ST_DIVZERO 1
`define MDU_ST_ILLEGAL 2
`define MDU_ST_DEST    8

// Arithmetic format major opcode and operation extension codes.
`define MDU_MAJOR      2'h2
`define MDU_EXT_MULSCC 6'h24
`define MDU_EXT_UMUL   6'h0A
`define MDU_EXT_SMUL   6'h0B
`define MDU_EXT_UMULCC 6'h1A
`define MDU_EXT_SMULCC 6'h1B
`define MDU_EXT_UDIV   6'h0E
`define MDU_EXT_SDIV   6'h0F
`define MDU_EXT_UDIVCC 6'h1E
`define MDU_EXT_SDIVCC 6'h1F

// Divide quotient limits and saturated results.
`define MDU_POS_LIM    64'h0000_0000_7FFF_FFFF
`define MDU_NEG_LIM    64'h0000_0000_8000_0000
`define MDU_SAT_U      32'hFFFF_FFFF
`define MDU_SAT_P      32'h7FFF_FFFF
`define MDU_SAT_N      32'h8000_0000

// Divider timing: one quotient bit per cycle.
`define MDU_DIV_STEPS  7'h40
`define MDU_DIV_LAST   7'h3F

`endif

// [mdu_pkg.sv]
// Types shared by the multiply/divide unit files.
package mdu_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [1:0]  major;
      logic [4:0]  dest_field;
      logic [5:0]  opcode_ext_field;
      logic [4:0]  src_a_field;
      logic        sel_imm;
      logic [12:0] signed_imm_field;
   } instr_t;

   typedef struct packed {
      logic below_zero;
      logic all_clear_flag;
      logic arith_excess_flag;
      logic arith_borrow_out;
   } proc_state_word_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DIVIDE
   } unit_state_t;

endpackage : mdu_pkg

// [mdu_divider.sv]
// Iterative 64 by 32 unsigned restoring divider, one quotient bit per cycle.
`timescale 1ns/1ps
`include "mdu_map.svh"
module mdu_divider (
   // Clock and reset.
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   // Start pulse with operands.
   input  wire logic        i_start,
   input  wire logic [63:0] i_dividend,
   input  wire logic [31:0] i_divisor,
   // Completion pulse with quotient.
   output logic             o_done,
   output logic [63:0]      o_quot
);

   logic [63:0] quot_q;
   logic [31:0] rem_q;
   logic [31:0] div_q;
   logic [6:0]  cnt_q;
   logic        run_q;
   logic        done_q;

   // Trial subtraction; the remainder stays below the divisor, so 32 bits do.
   wire [32:0] trial = {rem_q, quot_q[63]};
   wire [33:0] diff  = {1'b0, trial} - {2'h0, div_q};
   wire        ge    = ~diff[33];
   wire [31:0] rem_d = ge ? diff[31:0] : trial[31:0];

   // The dividend shifts out of quot_q as the quotient shifts in.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         quot_q <= 64'h0;
         rem_q  <= 32'h0;
         div_q  <= 32'h0;
         cnt_q  <= 7'h0;
         run_q  <= 1'b0;
         done_q <= 1'b0;
      end else if (i_start) begin
         quot_q <= i_dividend;
         rem_q  <= 32'h0;
         div_q  <= i_divisor;
         cnt_q  <= 7'h0;
         run_q  <= 1'b1;
         done_q <= 1'b0;
      end else begin
         done_q <= run_q & (cnt_q == `MDU_DIV_LAST);
         if (run_q) begin
            quot_q <= {quot_q[62:0], ge};
            rem_q  <= rem_d;
            cnt_q  <= cnt_q + 7'h1;
            run_q  <= cnt_q != `MDU_DIV_LAST;
         end
      end
   end

   assign o_done = done_q;
   assign o_quot = quot_q;

endmodule : mdu_divider

// [mdu_host_model.sv]
// Bus master model standing in for the decode stage and register file.
`timescale 1ns/1ps
module mdu_host_model (
   // Clock.
   input  wire logic              i_sys_clk,
   // Slave answer.
   input  wire logic [31:0]       i_prdata,
   input  wire logic              i_pready,
   input  wire logic              i_pslverr,
   // Request towards the unit.
   output mdu_pkg::apb_req_t      o_apb
);
   import mdu_pkg::*;

   // Idle bus at time zero so reset sees no request.
   initial begin
      o_apb = '0;
   end

   // One transfer: setup, access held until ready, then release.
   // Released address and data are inverted so stale values never match.
   task automatic xfer(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wdata, output logic [31:0] rdata,
                       output logic err);
      @(posedge i_sys_clk);
      o_apb.psel    <= 1'b1;
      o_apb.pwrite  <= wr;
      o_apb.paddr   <= addr;
      o_apb.pwdata  <= wdata;
      @(posedge i_sys_clk);
      o_apb.penable <= 1'b1;
      @(posedge i_sys_clk);
      while (i_pready !== 1'b1) begin
         @(posedge i_sys_clk);
      end
      rdata = i_prdata;
      err   = i_pslverr;
      o_apb.psel    <= 1'b0;
      o_apb.penable <= 1'b0;
      o_apb.paddr   <= ~addr;
      o_apb.pwdata  <= ~wdata;
   endtask : xfer
endmodule : mdu_host_model

// [int_multiply_divide_unit_tb.sv]
// Self-checking bench for the multiply/divide unit over its register bus.
`timescale 1ns/1ps
`include "mdu_map.svh"
module int_multiply_divide_unit_tb;
   import mdu_pkg::*;

   logic        i_sys_clk;
   logic        i_rstn;
   apb_req_t    apb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   int          miscompares;
   int          checks;

   int_multiply_divide_unit int_multiply_divide_unit_inst (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_apb     (apb),
      .o_prdata  (prdata),
      .o_pready  (pready),
      .o_pslverr (pslverr)
   );

   mdu_host_model mdu_host_model_inst (
      .i_sys_clk (i_sys_clk),
      .i_prdata  (prdata),
      .i_pready  (pready),
      .i_pslverr (pslverr),
      .o_apb     (apb)
   );

   // Free-running 200 MHz clock.
   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end

   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      mdu_host_model_inst.xfer(1'b1, a, d, r, e);
      chk({31'h0, e}, 32'h0, "write error");
   endtask : wr

   // Read and compare; also checks the error response.
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                      input logic experr);
      logic [31:0] r;
      logic        e;
      mdu_host_model_inst.xfer(1'b0, a, 32'h0, r, e);
      chk(r, exp, "read data");
      chk({31'h0, e}, {31'h0, experr}, "read error");
   endtask : rdc

   // Destination and source A name the same register, so results land
   // in place and chained steps accumulate.
   function automatic logic [31:0] mk(input logic [5:0] ext,
                                      input logic sel,
                                      input logic [12:0] imm);
      mk = {`MDU_MAJOR, 5'h02, ext, 5'h02, sel, imm};
   endfunction : mk

   // Load operands and flags, issue, then read back at once; the first
   // read waits out any divide, so it also proves the stall.
   task automatic op(input string nm, input logic [5:0] ext,
                     input logic sel, input logic [12:0] imm,
                     input logic [31:0] a, input logic [31:0] b,
                     input logic [31:0] y, input logic [3:0] fin,
                     input logic [31:0] er, input logic [31:0] ey,
                     input logic [3:0] ef);
      wr(`MDU_OPA_OFS, a);
      wr(`MDU_OPB_OFS, b);
      wr(`MDU_YEXT_OFS, y);
      wr(`MDU_FLAGS_OFS, {28'h0, fin});
      wr(`MDU_INSTR_OFS, mk(ext, sel, imm));
      rdc(`MDU_RESULT_OFS, er, 1'b0);
      rdc(`MDU_OPA_OFS, er, 1'b0);
      rdc(`MDU_YEXT_OFS, ey, 1'b0);
      rdc(`MDU_FLAGS_OFS, {28'h0, ef}, 1'b0);
      $display("test %s done", nm);
   endtask : op

   // Watchdog: the whole sequence needs under 3000 cycles.
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      miscompares++;
      $display("[ERR] %0t watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      miscompares = 0;
      checks      = 0;
      i_rstn      = 1'b0;
      repeat (8) @(posedge i_sys_clk);
      i_rstn <= 1'b1;
      rdc(`MDU_FLAGS_OFS, 32'h0, 1'b0);
      rdc(`MDU_STATUS_OFS, 32'h0, 1'b0);
      rdc(`MDU_RESULT_OFS, 32'h0, 1'b0);
      $display("test reset done");
      op("mstep_reg", `MDU_EXT_MULSCC, 1'b0, 13'h0003, 32'h5, 32'h3,
         32'h1, 4'h8, 32'h8000_0005, 32'h8000_0000, 4'h8);
      op("mstep_imm", `MDU_EXT_MULSCC, 1'b1, 13'h1FFF, 32'h4, 32'h0,
         32'h3, 4'h0, 32'h0000_0001, 32'h0000_0001, 4'h1);
      op("mstep_zero", `MDU_EXT_MULSCC, 1'b0, 13'h0000, 32'h7, 32'h1111_1111,
         32'h2, 4'h2, 32'h8000_0003, 32'h8000_0001, 4'h8);
      op("umul", `MDU_EXT_UMUL, 1'b0, 13'h0, 32'hFFFF_FFFF, 32'h2,
         32'h0, 4'h6, 32'hFFFF_FFFE, 32'h1, 4'h6);
      op("umulcc", `MDU_EXT_UMULCC, 1'b0, 13'h0, 32'hFFFF_FFFF, 32'h2,
         32'h0, 4'h3, 32'hFFFF_FFFE, 32'h1, 4'h8);
      op("smul", `MDU_EXT_SMUL, 1'b0, 13'h0, 32'hFFFF_FFFF, 32'h1,
         32'h0, 4'h5, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 4'h5);
      op("smulcc", `MDU_EXT_SMULCC, 1'b1, 13'h1000, 32'h0010_0000, 32'h0,
         32'h0, 4'hB, 32'h0, 32'hFFFF_FFFF, 4'h4);
      op("udiv", `MDU_EXT_UDIV, 1'b0, 13'h0, 32'h64, 32'h7,
         32'h0, 4'hF, 32'hE, 32'h0, 4'hF);
      op("udivcc_ovf", `MDU_EXT_UDIVCC, 1'b0, 13'h0, 32'h0, 32'h1,
         32'h1, 4'h5, 32'hFFFF_FFFF, 32'h1, 4'hA);
      op("sdiv_trunc", `MDU_EXT_SDIV, 1'b0, 13'h0, 32'hFFFF_FFFD, 32'h2,
         32'hFFFF_FFFF, 4'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 4'h0);
      op("sdivcc_pos", `MDU_EXT_SDIVCC, 1'b0, 13'h0, 32'h8000_0000, 32'h1,
         32'h0, 4'hD, 32'h7FFF_FFFF, 32'h0, 4'h2);
      op("sdivcc_neg", `MDU_EXT_SDIVCC, 1'b0, 13'h0, 32'h7FFF_FFFF, 32'h1,
         32'hFFFF_FFFF, 4'h0, 32'h8000_0000, 32'hFFFF_FFFF, 4'hA);
      op("sdivcc_zero", `MDU_EXT_SDIVCC, 1'b1, 13'h0002, 32'h1, 32'h0,
         32'h0, 4'hA, 32'h0, 32'h0, 4'h4);
      // Read-only result ignores writes.
      wr(`MDU_RESULT_OFS, 32'h1234_5678);
      rdc(`MDU_RESULT_OFS, 32'h0, 1'b0);
      // Zero divisor and undecodable words only raise status bits.
      wr(`MDU_OPB_OFS, 32'h0);
      wr(`MDU_INSTR_OFS, mk(`MDU_EXT_UDIV, 1'b0, 13'h0));
      rdc(`MDU_STATUS_OFS, 32'h0000_0202, 1'b0);
      wr(`MDU_INSTR_OFS, mk(6'h00, 1'b0, 13'h0));
      rdc(`MDU_STATUS_OFS, 32'h0000_0204, 1'b0);
      // A word shifted off the format: wrong major code, destination 0x10.
      wr(`MDU_INSTR_OFS, mk(`MDU_EXT_UMUL, 1'b0, 13'h0) >> 2);
      rdc(`MDU_STATUS_OFS, 32'h0000_1004, 1'b0);
      rdc(8'h1C, 32'h0, 1'b1);
      $display("test refusals done");
      report_and_stop();
   end
endmodule : int_multiply_divide_unit_tb
